// file: logic/srwl_key_seq.sv
// unlock key sequencer
`timescale 1ns/1ps
module srwl_key_seq (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire srwl_pkg::srwl_wr_type wr,
    output logic unlocked
);
    import srwl_pkg::*;

    srwl_state_type state_ff;
    srwl_state_type nxt_state;
    wire logic key_wr = wr.valid && (wr.index == IDX_KEY);
    wire logic other_wr = wr.valid && (wr.index != IDX_KEY);
    wire logic is_first = wr.data == KEY_FIRST;
    wire logic is_second = wr.data == KEY_SECOND;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SRWL_LOCKED: begin
                if (key_wr && is_first) begin
                    nxt_state = SRWL_HALF;
                end
            end
            SRWL_HALF: begin
                if (other_wr) begin
                    nxt_state = SRWL_LOCKED;
                end else if (key_wr) begin
                    // wrong second key restarts; a repeated first key re-arms
                    nxt_state = is_second ? SRWL_OPEN : (is_first ? SRWL_HALF : SRWL_LOCKED);
                end
            end
            SRWL_OPEN: begin
                // both keys count as valid here, any other key register value relocks
                if (key_wr && !is_first && !is_second) begin
                    nxt_state = SRWL_LOCKED;
                end
            end
            default: nxt_state = SRWL_LOCKED;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= SRWL_LOCKED;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign unlocked = (state_ff == SRWL_OPEN);
endmodule

// file: logic/srwl_pkg.sv
// shared constants and types for the system register write lock
package srwl_pkg;
    localparam logic [31:0] KEY_FIRST = 32'haa996655;
    localparam logic [31:0] KEY_SECOND = 32'h556699aa;
    localparam int NUM_PROT = 8;
    localparam logic [3:0] IDX_OSC = 4'h0;
    localparam logic [3:0] IDX_PLL = 4'h1;
    localparam logic [3:0] IDX_TUNE = 4'h2;
    localparam logic [3:0] IDX_PMD = 4'h3;
    localparam logic [3:0] IDX_SWRST = 4'h4;
    localparam logic [3:0] IDX_PINSEL = 4'h5;
    localparam logic [3:0] IDX_PWR = 4'h6;
    localparam logic [3:0] IDX_CAL = 4'h7;
    localparam logic [3:0] IDX_KEY = 4'h8;
    localparam logic [31:0] PROT_RESET = 32'h00000000;
    localparam logic [31:0] STATUS_LOCKED = 32'h00000000;
    localparam logic [31:0] STATUS_UNLOCKED = 32'h00000001;

    typedef enum logic [1:0] {
        SRWL_LOCKED = 2'b00,
        SRWL_HALF = 2'b01,
        SRWL_OPEN = 2'b10
    } srwl_state_type;

    // one write request from the processor or dma bus
    typedef struct packed {
        logic valid;
        logic [3:0] index;
        logic [31:0] data;
    } srwl_wr_type;
endpackage

// file: logic/srwl_top.sv
// protected system registers behind the write lock
`timescale 1ns/1ps
// How it works
// - protected registers keep their contents on writes while locked.
// - unlock needs key one then key two, idle bus cycles allowed between them.
// - once unlocked, any non-key write to the key register relocks.
// - a write elsewhere between the two keys abandons the unlock.
// - key register reads zero when locked, one when unlocked.
// - eight registers are protected: oscillator through calendar control.
module srwl_top (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire srwl_pkg::srwl_wr_type wr,
    input wire logic rd_en,
    input wire logic [3:0] rd_index,
    output logic wr_done,
    output logic [31:0] rd_data,
    output logic [31:0] oscillator_control,
    output logic [31:0] pll_control,
    output logic [31:0] frc_tuning,
    output logic [31:0] module_disable_control,
    output logic [31:0] software_reset_trigger,
    output logic [31:0] pin_select_config,
    output logic [31:0] sleep_power_control,
    output logic [31:0] calendar_clock_control,
    output logic unlocked
);
    import srwl_pkg::*;

    logic [31:0] prot_ff [NUM_PROT];
    logic [31:0] rd_data_ff;
    logic unlock_w;

    // key register decode, shared by the sequences and checks below
    function automatic logic key_hit(input srwl_wr_type w);
        return w.valid && (w.index == IDX_KEY);
    endfunction

    function automatic logic key_is(input srwl_wr_type w, input logic [31:0] k);
        return key_hit(w) && (w.data == k);
    endfunction

    function automatic logic foreign_hit(input srwl_wr_type w);
        return w.valid && (w.index != IDX_KEY);
    endfunction

    srwl_key_seq u_seq (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .wr(wr),
        .unlocked(unlock_w)
    );

    wire logic prot_hit = wr.valid && (wr.index < IDX_KEY);
    wire logic prot_we = prot_hit && unlock_w;
    wire logic [2:0] prot_sel = wr.index[2:0];
    wire logic [31:0] status_w = unlock_w ? STATUS_UNLOCKED : STATUS_LOCKED;
    wire logic [31:0] nxt_rd_data = (rd_index == IDX_KEY) ? status_w :
        (rd_index < IDX_KEY) ? prot_ff[rd_index[2:0]] : 32'h00000000;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_PROT; i++) begin
                prot_ff[i] <= PROT_RESET;
            end
        end else if (prot_we) begin
            prot_ff[prot_sel] <= wr.data;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rd_data_ff <= 32'h00000000;
        end else if (rd_en) begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    // every write completes, locked or not, so the bus never hangs
    assign wr_done = wr.valid;
    assign rd_data = rd_data_ff;
    assign unlocked = unlock_w;
    assign oscillator_control = prot_ff[IDX_OSC[2:0]];
    assign pll_control = prot_ff[IDX_PLL[2:0]];
    assign frc_tuning = prot_ff[IDX_TUNE[2:0]];
    assign module_disable_control = prot_ff[IDX_PMD[2:0]];
    assign software_reset_trigger = prot_ff[IDX_SWRST[2:0]];
    assign pin_select_config = prot_ff[IDX_PINSEL[2:0]];
    assign sleep_power_control = prot_ff[IDX_PWR[2:0]];
    assign calendar_clock_control = prot_ff[IDX_CAL[2:0]];

    chk_locked_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        (prot_hit && !unlock_w) |=> (prot_ff[$past(prot_sel)] == $past(prot_ff[prot_sel])))
        else $error("protected register changed while locked");

    sequence key_pair;
        (wr.valid && wr.index == IDX_KEY && wr.data == KEY_FIRST && !unlock_w) ##1
        (wr.valid && wr.index == IDX_KEY && wr.data == KEY_SECOND);
    endsequence
    chk_unlock_pair: assert property (@(posedge ref_clk) disable iff (!rstn)
        key_pair |=> unlock_w)
        else $error("key pair did not unlock");

    chk_relock_nonkey: assert property (@(posedge ref_clk) disable iff (!rstn)
        (unlock_w && wr.valid && wr.index == IDX_KEY && wr.data != KEY_FIRST
         && wr.data != KEY_SECOND) |=> !unlock_w)
        else $error("non-key write did not relock");

    chk_abort_foreign: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!unlock_w && wr.valid && wr.index == IDX_KEY && wr.data == KEY_FIRST) ##1
        (wr.valid && wr.index != IDX_KEY) ##1
        (wr.valid && wr.index == IDX_KEY && wr.data == KEY_SECOND) |=> !unlock_w)
        else $error("foreign write did not abandon unlock");

    chk_status_read: assert property (@(posedge ref_clk) disable iff (!rstn)
        (rd_en && rd_index == IDX_KEY) |=> (rd_data == {31'h0, $past(unlock_w)}))
        else $error("key register status read wrong");

    chk_unlock_cause: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!unlock_w ##1 unlock_w) |-> $past(wr.valid && wr.index == IDX_KEY
         && wr.data == KEY_SECOND))
        else $error("unlock without second key");

    chk_write_done: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr.valid |-> wr_done)
        else $error("write not completed");

    chk_open_write: assert property (@(posedge ref_clk) disable iff (!rstn)
        (prot_hit && unlock_w) |=> (prot_ff[$past(prot_sel)] == $past(wr.data)))
        else $error("unlocked write not stored");

    // building blocks for the step-by-step checks below
    sequence first_key_s;
        key_is(wr, KEY_FIRST);
    endsequence

    sequence second_key_s;
        key_is(wr, KEY_SECOND);
    endsequence

    sequence foreign_s;
        foreign_hit(wr);
    endsequence

    sequence bad_key_s;
        key_hit(wr) && !key_is(wr, KEY_FIRST) && !key_is(wr, KEY_SECOND);
    endsequence

    // every protected output unchanged since the last edge
    sequence regs_still_s;
        $stable(oscillator_control) && $stable(pll_control) && $stable(frc_tuning)
        && $stable(module_disable_control) && $stable(software_reset_trigger)
        && $stable(pin_select_config) && $stable(sleep_power_control)
        && $stable(calendar_clock_control);
    endsequence

    // a wrong second key must send the sequencer back to the start
    chk_wrong_second: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!unlock_w && key_is(wr, KEY_FIRST)) ##1 bad_key_s |=> !unlock_w)
        else $error("wrong second key unlocked");

    // one idle bus cycle between the keys does not break the pair
    chk_half_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!unlock_w && key_is(wr, KEY_FIRST)) ##1 !wr.valid ##1 second_key_s |=> unlock_w)
        else $error("idle gap broke key pair");

    // a foreign write still aborts when one idle cycle follows it
    chk_foreign_gap: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!unlock_w && key_is(wr, KEY_FIRST)) ##1 foreign_s ##1 !wr.valid ##1 second_key_s
        |=> !unlock_w)
        else $error("foreign write before gap did not abort");

    // the first key alone never opens the lock
    chk_first_alone: assert property (@(posedge ref_clk) disable iff (!rstn)
        first_key_s |=> (!unlock_w || $past(unlock_w)))
        else $error("first key alone unlocked");

    // only the second key can open a locked block
    chk_locked_stays: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!unlock_w && !key_is(wr, KEY_SECOND)) |=> !unlock_w)
        else $error("unlocked without second key");

    // valid keys written while open keep it open
    chk_open_keys: assert property (@(posedge ref_clk) disable iff (!rstn)
        (unlock_w && (key_is(wr, KEY_FIRST) || key_is(wr, KEY_SECOND))) |=> unlock_w)
        else $error("valid key relocked");

    // writes elsewhere while open leave the lock open
    chk_open_foreign: assert property (@(posedge ref_clk) disable iff (!rstn)
        (unlock_w && foreign_hit(wr)) |=> unlock_w)
        else $error("foreign write relocked");

    chk_relock_cause: assert property (@(posedge ref_clk) disable iff (!rstn)
        (unlock_w ##1 !unlock_w) |-> $past(key_hit(wr) && wr.data != KEY_FIRST
         && wr.data != KEY_SECOND))
        else $error("relock without non-key write");

    chk_rd_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        !rd_en |=> $stable(rd_data))
        else $error("read data changed without read");

    chk_prot_read: assert property (@(posedge ref_clk) disable iff (!rstn)
        (rd_en && rd_index < IDX_KEY) |=> (rd_data == $past(prot_ff[rd_index[2:0]])))
        else $error("protected register read wrong");

    chk_unmapped_read: assert property (@(posedge ref_clk) disable iff (!rstn)
        (rd_en && rd_index > IDX_KEY) |=> (rd_data == 32'h00000000))
        else $error("unmapped read not zero");

    // nothing may move the protected set without an open write
    chk_idle_regs: assert property (@(posedge ref_clk) disable iff (!rstn)
        !(wr.valid && unlock_w) |=> regs_still_s)
        else $error("protected register moved without open write");

    // key and unmapped writes never land in the protected set
    chk_key_unstored: assert property (@(posedge ref_clk) disable iff (!rstn)
        (wr.valid && wr.index >= IDX_KEY) |=> regs_still_s)
        else $error("key write stored in protected register");

    chk_done_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
        !wr.valid |-> !wr_done)
        else $error("write done without write");
endmodule

// file: test/srwl_bus_model.sv
// processor bus master model issuing register writes and reads
`timescale 1ns/1ps
module srwl_bus_model (
    input wire logic ref_clk,
    output srwl_pkg::srwl_wr_type wr,
    output logic rd_en,
    output logic [3:0] rd_index
);
    import srwl_pkg::*;
    initial begin
        wr = '0;
        rd_en = 1'b0;
        rd_index = 4'h0;
    end
    // hold keeps valid up so the next call lands back to back
    task automatic write(input logic [3:0] i, input logic [31:0] d, input logic hold);
        wr <= '{valid: 1'b1, index: i, data: d};
        @(negedge ref_clk);
        if (!hold) begin
            // released bus shows inverted data so stale words never match
            wr <= '{valid: 1'b0, index: ~i, data: ~d};
            @(negedge ref_clk);
        end
    endtask
    task automatic read(input logic [3:0] i);
        rd_en <= 1'b1;
        rd_index <= i;
        @(negedge ref_clk);
        rd_en <= 1'b0;
        rd_index <= ~i;
    endtask
endmodule

// file: test/srwl_top_tb_top.sv
// self-checking bench for the system register write lock
`timescale 1ns/1ps
module srwl_top_tb_top;
    import srwl_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    srwl_wr_type wr;
    logic rd_en, wr_done, unlocked, h;
    logic [3:0] rd_index;
    logic [31:0] rd_data, s;
    logic [31:0] ro [8];
    logic [31:0] rm [8];
    int mismatches = 0;
    int n_checks = 0;
    int st = 0;
    localparam logic [36:0] DIR [14] = '{{5'h00, 32'ha5a5}, {5'h18, 32'h0}, {5'h18, KEY_FIRST},
        {5'h08, KEY_SECOND}, {5'h08, KEY_FIRST}, {5'h08, 32'h0}, {5'h18, KEY_FIRST},
        {5'h19, 32'h3}, {5'h08, KEY_SECOND}, {5'h18, KEY_FIRST}, {5'h18, 32'h5},
        {5'h08, KEY_SECOND}, {5'h08, KEY_FIRST}, {5'h08, KEY_SECOND}};
    srwl_bus_model srwl_bus_model_i (.ref_clk(ref_clk), .wr(wr), .rd_en(rd_en),
        .rd_index(rd_index));
    srwl_top srwl_top_i (.ref_clk(ref_clk), .rstn(rstn), .wr(wr), .rd_en(rd_en),
        .rd_index(rd_index), .wr_done(wr_done), .rd_data(rd_data),
        .oscillator_control(ro[0]), .pll_control(ro[1]), .frc_tuning(ro[2]),
        .module_disable_control(ro[3]), .software_reset_trigger(ro[4]),
        .pin_select_config(ro[5]), .sleep_power_control(ro[6]),
        .calendar_clock_control(ro[7]), .unlocked(unlocked));
    initial forever #12.5 ref_clk = ~ref_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
        n_checks++;
        if (v !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, v);
        end
    endtask
    task automatic cmp_out();
        chk("unlocked", {31'h0, st == 2}, {31'h0, unlocked});
        foreach (rm[k]) chk("prot_reg", rm[k], ro[k]);
    endtask
    task automatic w(input logic [3:0] i, input logic [31:0] d, input logic hd);
        logic op;
        op = (st == 2);
        if (i == IDX_KEY)
            st = (d == KEY_FIRST) ? (op ? 2 : 1) : (d == KEY_SECOND) ? (st == 0 ? 0 : 2) : 0;
        else if (st == 1)
            st = 0;
        if (op && i < 8) rm[i] = d;
        srwl_bus_model_i.write(i, d, hd);
        cmp_out();
    endtask
    task automatic r(input logic [3:0] i);
        srwl_bus_model_i.read(i);
        chk("rd_data", (i == IDX_KEY) ? {31'h0, st == 2} : (i < 8) ? rm[i] : 32'h0, rd_data);
    endtask
    task automatic rst();
        rstn <= 1'b0;
        repeat (2) @(negedge ref_clk);
        rstn <= 1'b1;
        st = 0;
        foreach (rm[k]) rm[k] = PROT_RESET;
        cmp_out();
    endtask
    always @(posedge ref_clk) if (wr.valid === 1'b1) chk("wr_done", 32'h1, {31'h0, wr_done});
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #(25 * 20000);
        mismatches++;
        finish_test();
    end
    initial begin
        s = 32'h00000044;
        @(negedge ref_clk);
        rst();
        r(IDX_KEY);
        foreach (DIR[k]) w(DIR[k][35:32], DIR[k][31:0], DIR[k][36]);
        for (int k = 0; k < 8; k++) w(4'(k), 32'h100 + k, 1'b0);
        for (int n = 0; n < 300; n++) begin
            s = lfsr(s);
            h = s[6] && n != 299;
            w(s[3] ? IDX_KEY : s[12:9], s[5:4] == 2'h0 ? KEY_FIRST : s[5:4] == 2'h1 ? KEY_SECOND : s, h);
            if (!h) r(s[16:13]);
        end
        rst();
        for (int t = 0; t < 4 && rd_data !== STATUS_UNLOCKED; t++) begin
            w(IDX_KEY, 32'h0, 1'b1);
            w(IDX_KEY, KEY_FIRST, t != 0);
            if (t == 0) w(4'h9, 32'h0, 1'b1);
            w(IDX_KEY, KEY_SECOND, 1'b0);
            r(IDX_KEY);
        end
        finish_test();
    end
endmodule
